// *** logic/pbp_defs.svh ***
// Constants for the parallel host bus port: pin indices, idle levels and timing counts.
// Assumes a single 20 MHz clock on both ends of the port.
`ifndef PBP_DEFS_SVH
`define PBP_DEFS_SVH

// =============================================================
// Synchroniser lanes of the device end
`define PBP_PIN_CE 4
`define PBP_PIN_RD 3
`define PBP_PIN_WR 2
`define PBP_PIN_FRAME 1
`define PBP_PIN_RSTN 0
`define PBP_PIN_IDLE 5'h1D

// =============================================================
// Bus levels
`define PBP_BUS_PULL 8'hFF
`define PBP_TDO_IDLE 1'h0

// =============================================================
// Host timing, cycles minus one
`define PBP_SETUP_CYC 8'h01
`define PBP_STROBE_CYC 8'h09
`define PBP_HOLD_CYC 8'h03
`define PBP_FRAME_PULSE_CYC 8'h03

`endif

// *** logic/pbp_pkg.sv ***
// Types for the parallel host bus port.
// Assumes pbp_defs.svh is on the include path.
`include "pbp_defs.svh"

package pbp_pkg;

    // =========================================================
    // Device end state
    typedef struct packed {
        logic [4:0] pinS1;
        logic [4:0] pinS2;
        logic [4:0] pinS3;
        logic [7:0] addrS1;
        logic [7:0] addrS2;
        logic [7:0] dataS1;
        logic [7:0] dataS2;
        logic wrOpen;
        logic rdOpen;
        logic [7:0] addr;
        logic [7:0] wrData;
        logic [7:0] rdData;
        logic rdOe;
        logic regWr;
        logic regRd;
        logic irqOe;
        logic frameStart;
        logic hwReset;
    } pbp_dev_t;

    // =========================================================
    // Host end state
    typedef enum logic [1:0] {
        HIDLE,
        HSETUP,
        HSTROBE,
        HHOLD
    } pbp_hstate_t;

    typedef struct packed {
        pbp_hstate_t st;
        logic [7:0] cnt;
        logic write;
        logic ceN;
        logic rdN;
        logic wrN;
        logic [7:0] addr;
        logic [7:0] data;
        logic dataOe;
        logic [7:0] datS1;
        logic [7:0] datS2;
        logic [7:0] rdData;
        logic rspValid;
        logic irqS1;
        logic irqS2;
        logic [7:0] framePulseCnt;
        logic framePulse;
        logic rstOe;
    } pbp_host_t;

endpackage

// *** logic/pbp_bus_if.sv ***
// Pin bundle between the host end and the device end.
// Resolves the shared data bus, open-drain interrupt and pulled-up reset.
`timescale 1ns/1ps
`default_nettype none
`include "pbp_defs.svh"

interface pbp_bus_if;
    logic ceN;
    logic rdN;
    logic wrN;
    logic [7:0] addr;
    logic [7:0] hostData;
    logic hostDataOe;
    logic [7:0] devData;
    logic devDataOe;
    logic [7:0] dataBus;
    logic irqOe;
    logic irqN;
    logic frameTrigger;
    logic hwResetOe;
    logic hwResetN;
    logic jtagTrst;
    logic jtagTms;
    logic jtagTck;
    logic jtagTdi;
    logic jtagTdo;

    // =========================================================
    // Wire resolution
    assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : `PBP_BUS_PULL);
    assign irqN = ~irqOe;
    assign hwResetN = ~hwResetOe;

    modport dev (
        input ceN, rdN, wrN, addr, dataBus, frameTrigger, hwResetN,
        output devData, devDataOe, irqOe, jtagTdo
    );

    modport host (
        output ceN, rdN, wrN, addr, hostData, hostDataOe, frameTrigger, hwResetOe,
        output jtagTrst, jtagTms, jtagTck, jtagTdi,
        input dataBus, irqN, jtagTdo
    );
endinterface

`default_nettype wire

// *** logic/pbp_device_end.sv ***
// Device end of the parallel host bus port.
// Assumes asynchronous pins on the bus side and a register file on the user side
// that answers a read combinationally, in the same cycle as regRdEn.
//
// Functional notes
// - Write loads data at strobe rising edge
// - Chip enable may stay low or toggle
// - Read starts at falling read strobe
// - Chip enable high releases bus, ignores falling strobes
// - Toggle enable with reads during initialisation
// - Interrupt is active low open drain
// - Trigger event starts a new frame
// - Low reset pin restores power-on state
// - Test pins held at normal-operation levels
// - Address captured when a strobe falls
`timescale 1ns/1ps
`default_nettype none
`include "pbp_defs.svh"

module pbp_device_end
    import pbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pbp_bus_if.dev bus,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic irqReq,
    output logic frameStart,
    output logic hwResetReq
);

    // =========================================================
    // Helpers
    // High for one cycle after a lane falls
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction

    // High for one cycle after a lane rises
    function automatic logic rose(input logic prev, input logic cur);
        rose = ~prev & cur;
    endfunction

    // New access only with enable low and nothing open
    function automatic logic accessFree(input logic ceIsLow, input pbp_dev_t s);
        accessFree = ceIsLow & ~s.rdOpen & ~s.wrOpen;
    endfunction

    // Clears state, optionally keeping the pin pipelines
    function automatic pbp_dev_t devClear(input logic keepSync, input pbp_dev_t s);
        pbp_dev_t r;
        r = '0;
        if (keepSync) begin
            r.pinS1 = s.pinS1;
            r.pinS2 = s.pinS2;
            r.pinS3 = s.pinS3;
            r.addrS1 = s.addrS1;
            r.addrS2 = s.addrS2;
            r.dataS1 = s.dataS1;
            r.dataS2 = s.dataS2;
        end else begin
            r.pinS1 = `PBP_PIN_IDLE;
            r.pinS2 = `PBP_PIN_IDLE;
            r.pinS3 = `PBP_PIN_IDLE;
        end
        devClear = r;
    endfunction

    // =========================================================
    // State
    pbp_dev_t q;
    pbp_dev_t next_q;

    // =========================================================
    // Synchronised pin events
    logic ceLow;
    logic rdFall;
    logic rdRise;
    logic wrFall;
    logic wrRise;
    logic frameRise;

    // =========================================================
    // Edge detection between the second and third stages
    always_comb begin
        ceLow = ~q.pinS2[`PBP_PIN_CE];
        rdFall = fell(q.pinS3[`PBP_PIN_RD], q.pinS2[`PBP_PIN_RD]);
        rdRise = rose(q.pinS3[`PBP_PIN_RD], q.pinS2[`PBP_PIN_RD]);
        wrFall = fell(q.pinS3[`PBP_PIN_WR], q.pinS2[`PBP_PIN_WR]);
        wrRise = rose(q.pinS3[`PBP_PIN_WR], q.pinS2[`PBP_PIN_WR]);
        frameRise = rose(q.pinS3[`PBP_PIN_FRAME], q.pinS2[`PBP_PIN_FRAME]);
    end

    // =========================================================
    // Next state
    always_comb begin
        next_q = q;

        // =====================================================
        // Two-stage synchronisers
        next_q.pinS1[`PBP_PIN_CE] = bus.ceN;
        next_q.pinS1[`PBP_PIN_RD] = bus.rdN;
        next_q.pinS1[`PBP_PIN_WR] = bus.wrN;
        next_q.pinS1[`PBP_PIN_FRAME] = bus.frameTrigger;
        next_q.pinS1[`PBP_PIN_RSTN] = bus.hwResetN;
        next_q.pinS2 = q.pinS1;
        next_q.pinS3 = q.pinS2;
        next_q.addrS1 = bus.addr;
        next_q.addrS2 = q.addrS1;
        next_q.dataS1 = bus.dataBus;
        next_q.dataS2 = q.dataS1;

        // =====================================================
        // Pulses and reset level default low
        next_q.regWr = 1'b0;
        next_q.regRd = 1'b0;
        next_q.frameStart = 1'b0;
        next_q.hwReset = 1'b0;

        // =====================================================
        // Read opens on falling strobe with enable low
        if (rdFall && accessFree(ceLow, q)) begin
            next_q.rdOpen = 1'b1;
            next_q.addr = q.addrS2;
            next_q.regRd = 1'b1;
        end

        // =====================================================
        // Write opens on falling strobe, read wins a tie
        if (wrFall && accessFree(ceLow, q) && !next_q.rdOpen) begin
            next_q.wrOpen = 1'b1;
            next_q.addr = q.addrS2;
        end

        // =====================================================
        // Write commits on rising strobe, enable held or toggled
        if (q.wrOpen && wrRise) begin
            next_q.wrOpen = 1'b0;
            next_q.regWr = 1'b1;
            next_q.wrData = q.dataS2;
        end

        // =====================================================
        // Read data from the register file
        if (q.regRd) begin
            next_q.rdData = regRdData;
        end

        // =====================================================
        // Read ends on rising strobe or enable high
        if (q.rdOpen && (rdRise || !ceLow)) begin
            next_q.rdOpen = 1'b0;
        end

        // =====================================================
        // Drive the bus only inside an open read
        next_q.rdOe = next_q.rdOpen && (q.regRd || q.rdOe);

        // =====================================================
        // Frame trigger event
        if (frameRise) begin
            next_q.frameStart = 1'b1;
        end

        // =====================================================
        // Interrupt pull-down
        next_q.irqOe = irqReq;

        // =====================================================
        // Reset pin returns port to power-on state
        if (!q.pinS2[`PBP_PIN_RSTN]) begin
            next_q = devClear(1'b1, next_q);
            next_q.hwReset = 1'b1;
        end

        // =====================================================
        // Port reset clears the pin pipelines too
        if (rst) begin
            next_q = devClear(1'b0, next_q);
        end
    end

    always_ff @(posedge clk) begin
        q <= next_q;
    end

    // =========================================================
    // Outputs
    assign bus.devData = q.rdData;
    assign bus.devDataOe = q.rdOe;
    assign bus.irqOe = q.irqOe;
    assign bus.jtagTdo = `PBP_TDO_IDLE;
    assign regAddr = q.addr;
    assign regWrData = q.wrData;
    assign regWrEn = q.regWr;
    assign regRdEn = q.regRd;
    assign frameStart = q.frameStart;
    assign hwResetReq = q.hwReset;

endmodule

`default_nettype wire

// *** logic/pbp_host_end.sv ***
// Host end of the parallel host bus port.
// Assumes one request at a time from user logic; runs on its own clk.
`timescale 1ns/1ps
`default_nettype none
`include "pbp_defs.svh"

module pbp_host_end
    import pbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pbp_bus_if.host bus,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [7:0] reqAddr,
    input wire logic [7:0] reqWrData,
    output logic reqReady,
    output logic rspValid,
    output logic [7:0] rspData,
    input wire logic initMode,
    input wire logic holdCe,
    input wire logic frameReq,
    input wire logic resetReq,
    output logic irqPending
);

    function automatic logic [7:0] dec(input logic [7:0] v);
        dec = v - 8'h01;
    endfunction

    pbp_host_t q;
    pbp_host_t next_q;
    logic keepCe;

    // =========================================================
    // Next state
    always_comb begin
        next_q = q;
        keepCe = holdCe && !initMode;
        next_q.datS1 = bus.dataBus;
        next_q.datS2 = q.datS1;
        next_q.irqS1 = bus.irqN;
        next_q.irqS2 = q.irqS1;
        next_q.rspValid = 1'b0;
        next_q.rstOe = resetReq;
        next_q.cnt = dec(q.cnt);
        case (q.st)
            HIDLE: begin
                if (reqValid) begin
                    next_q.st = HSETUP;
                    next_q.cnt = `PBP_SETUP_CYC;
                    next_q.write = reqWrite;
                    next_q.addr = reqAddr;
                    next_q.data = reqWrData;
                    next_q.dataOe = reqWrite;
                    next_q.ceN = 1'b0;
                end else if (!keepCe) begin
                    next_q.ceN = 1'b1;
                end
            end
            HSETUP: begin
                if (q.cnt == 8'h00) begin
                    next_q.st = HSTROBE;
                    next_q.cnt = `PBP_STROBE_CYC;
                    next_q.rdN = q.write;
                    next_q.wrN = ~q.write;
                end
            end
            HSTROBE: begin
                if (q.cnt == 8'h00) begin
                    next_q.st = HHOLD;
                    next_q.cnt = `PBP_HOLD_CYC;
                    next_q.rdN = 1'b1;
                    next_q.wrN = 1'b1;
                    next_q.rdData = q.datS2;
                    // Enable rises with the strobe unless held for writes
                    next_q.ceN = !(q.write && keepCe);
                end
            end
            HHOLD: begin
                // Data held past the rising write strobe
                if (q.cnt == 8'h00) begin
                    next_q.st = HIDLE;
                    next_q.dataOe = 1'b0;
                    next_q.rspValid = 1'b1;
                end
            end
            default: begin
                next_q.st = HIDLE;
            end
        endcase
        if (frameReq) begin
            next_q.framePulseCnt = `PBP_FRAME_PULSE_CYC;
            next_q.framePulse = 1'b1;
        end else if (q.framePulseCnt != 8'h00) begin
            next_q.framePulseCnt = dec(q.framePulseCnt);
        end else begin
            next_q.framePulse = 1'b0;
        end
        if (rst) begin
            next_q = '0;
            next_q.st = HIDLE;
            next_q.ceN = 1'b1;
            next_q.rdN = 1'b1;
            next_q.wrN = 1'b1;
            next_q.irqS1 = 1'b1;
            next_q.irqS2 = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= next_q;
    end

    // =========================================================
    // Outputs
    assign bus.ceN = q.ceN;
    assign bus.rdN = q.rdN;
    assign bus.wrN = q.wrN;
    assign bus.addr = q.addr;
    assign bus.hostData = q.data;
    assign bus.hostDataOe = q.dataOe;
    assign bus.frameTrigger = q.framePulse;
    assign bus.hwResetOe = q.rstOe;
    // Test pins at normal-operation levels
    assign bus.jtagTrst = 1'b0;
    assign bus.jtagTms = 1'b1;
    assign bus.jtagTck = 1'b1;
    assign bus.jtagTdi = 1'b1;
    assign reqReady = (q.st == HIDLE);
    assign rspValid = q.rspValid;
    assign rspData = q.rdData;
    assign irqPending = ~q.irqS2;

endmodule

`default_nettype wire

// *** sim/pbp_bus_asserts.sv ***
// Checker for the pins between the host end and the device end of the port.
// Assumes one clock and a synchronous active-high reset; sees interface signals only.
`timescale 1ns/1ps
`default_nettype none

module pbp_bus_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic ceN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic [7:0] dataBus,
    input wire logic devDataOe,
    input wire logic irqOe,
    input wire logic hwResetN,
    input wire logic frameTrigger,
    input wire logic jtagTrst,
    input wire logic jtagTms,
    input wire logic jtagTck,
    input wire logic jtagTdi
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // =========================================================
    // Read path
    AST_RD_LATENCY: assert property ($fell(rdN) && !ceN && hwResetN |-> ##[3:5] devDataOe)
        else $error("read data not driven in time");
    AST_RD_NO_EARLY: assert property ($fell(rdN) |-> !devDataOe [*2])
        else $error("bus driven before read synchronised");
    AST_RD_DRIVE: assert property (devDataOe |-> !$past(rdN, 3) && !$past(ceN, 3))
        else $error("bus driven without read strobe");
    AST_CE_RELEASE: assert property (ceN [*4] |-> !devDataOe)
        else $error("bus driven with chip enable high");

    // =========================================================
    // Write path
    AST_WR_NO_DRIVE: assert property (!wrN |-> !devDataOe)
        else $error("device drives bus during write");
    AST_WR_DATA: assert property ($fell(wrN) |-> ($stable(dataBus) && !ceN) [*8])
        else $error("write data or enable moved during strobe");

    // =========================================================
    // Side pins
    AST_FRAME_PULSE: assert property ($rose(frameTrigger) |-> frameTrigger [*4] ##[1:2] !frameTrigger)
        else $error("trigger pulse length wrong");
    AST_RESET_QUIET: assert property (!hwResetN [*4] |-> !devDataOe && !irqOe)
        else $error("device active while reset pin low");
    AST_JTAG: assert property (!jtagTrst && jtagTms && jtagTck && jtagTdi)
        else $error("test pins not at normal levels");

    cover property ($fell(rdN) && !ceN);
    cover property ($fell(wrN) && !ceN);
    cover property ($rose(frameTrigger));
    cover property (!hwResetN);
endmodule

`default_nettype wire

// *** sim/parallel_host_bus_port_tb.sv ***
// Testbench: host end and device end joined by the pin interface.
// Assumes the logic/ files are compiled first; the bench plays the register file.
`timescale 1ns/1ps
`default_nettype none

module parallel_host_bus_port_tb;
    import pbp_pkg::*;
    logic clk = 0, rst = 1, reqValid = 0, reqWrite = 0, initMode = 0, holdCe = 0;
    logic frameReq = 0, resetReq = 0, irqReq = 0, reqReady, rspValid, irqPending;
    logic regWrEn, regRdEn, frameStart, hwResetReq;
    logic [7:0] reqAddr = 8'h00, reqWrData = 8'h00, rspData, regAddr, regWrData, regRdData;
    logic [7:0] mem [256];
    logic [7:0] shadow [256];
    logic [15:0] wq [$];
    logic [9:0] rq [$];
    logic tq [$];
    logic [9:0] n;
    int fails = 0, check_count = 0;

    pbp_bus_if bus();
    pbp_host_end i_pbp_host_end (.clk(clk), .rst(rst), .bus(bus), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWrData(reqWrData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .initMode(initMode), .holdCe(holdCe),
        .frameReq(frameReq), .resetReq(resetReq), .irqPending(irqPending));
    pbp_device_end i_pbp_device_end (.clk(clk), .rst(rst), .bus(bus), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .irqReq(irqReq), .frameStart(frameStart), .hwResetReq(hwResetReq));
    pbp_bus_asserts i_pbp_bus_asserts (.clk(clk), .rst(rst), .ceN(bus.ceN), .rdN(bus.rdN),
        .wrN(bus.wrN), .dataBus(bus.dataBus), .devDataOe(bus.devDataOe), .irqOe(bus.irqOe),
        .hwResetN(bus.hwResetN), .frameTrigger(bus.frameTrigger), .jtagTrst(bus.jtagTrst),
        .jtagTms(bus.jtagTms), .jtagTck(bus.jtagTck), .jtagTdi(bus.jtagTdi));

    // =========================================================
    // Clock and register file
    initial forever #25 clk = ~clk;
    assign regRdData = mem[regAddr];
    always @(posedge clk) if (regWrEn === 1'b1) mem[regAddr] <= regWrData;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        while (reqReady !== 1'b1) @(negedge clk);
        reqValid = 1;
        reqWrite = w;
        reqAddr = a;
        reqWrData = d;
        initMode = 1'($urandom_range(1));
        holdCe = 1'($urandom_range(1));
        if (w) begin
            shadow[a] = d;
            wq.push_back({a, d});
        end
        rq.push_back({!(w && holdCe && !initMode), !w, shadow[a]});
        @(negedge clk);
        reqValid = 0;
    endtask

    // =========================================================
    // Result monitor
    always @(negedge clk) begin
        if (regWrEn === 1'b1) chk({regAddr, regWrData}, wq.size() ? wq.pop_front() : 16'hxxxx);
        if (rspValid === 1'b1) begin
            n = rq.size() ? rq.pop_front() : {2'b11, 8'hxx};
            if (n[8]) chk(rspData, n[7:0]);
            chk(bus.ceN, n[9]);
            chk(bus.devDataOe, 16'h0000);
        end
        if (frameStart === 1'b1) chk(tq.size() ? 16'h0001 : 16'h0000, 16'h0001);
        if (frameStart === 1'b1 && tq.size()) void'(tq.pop_front());
    end

    initial begin
        #500000;
        fails++;
        stop_test();
    end

    // =========================================================
    // Scenarios
    initial begin
        void'($urandom(32'h5890_c4f4));
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
            shadow[i] = 8'h00;
        end
        repeat (5) @(negedge clk);
        rst = 0;
        repeat (3) @(negedge clk);
        chk({bus.jtagTrst, bus.jtagTms, bus.jtagTck, bus.jtagTdi}, 16'h0007);
        for (int i = 0; i < 10; i++) xfer(1, 8'(i < 8 ? 1 << i : (i == 8 ? 0 : 255)), 8'($urandom));
        for (int i = 0; i < 10; i++) xfer(0, 8'(i < 8 ? 1 << i : (i == 8 ? 0 : 255)), 8'h00);
        for (int i = 0; i < 40; i++) xfer(1'($urandom_range(1)), 8'($urandom), 8'($urandom));
        irqReq = 1;
        repeat (6) @(negedge clk);
        chk({bus.irqN, irqPending}, 16'h0001);
        irqReq = 0;
        repeat (6) @(negedge clk);
        chk({bus.irqN, irqPending}, 16'h0002);
        tq.push_back(1'b1);
        frameReq = 1;
        @(negedge clk);
        frameReq = 0;
        repeat (12) @(negedge clk);
        chk(16'(tq.size()), 16'h0000);
        resetReq = 1;
        irqReq = 1;
        repeat (8) @(negedge clk);
        chk({hwResetReq, bus.devDataOe, bus.hwResetN, bus.irqN}, 16'h0009);
        resetReq = 0;
        irqReq = 0;
        repeat (8) @(negedge clk);
        chk(hwResetReq, 16'h0000);
        xfer(1, 8'h5A, 8'hC3);
        xfer(0, 8'h5A, 8'h00);
        repeat (40) @(negedge clk);
        chk(16'(wq.size() + rq.size()), 16'h0000);
        stop_test();
    end
endmodule

`default_nettype wire
